// ### flash_prot_params.svh
// Timing and encoding constants for the flash protection host controller
`ifndef FLASH_PROT_PARAMS_SVH
`define FLASH_PROT_PARAMS_SVH

// ==========================================================
// Clock and bus timing
`define CLK_PERIOD_NS 8
`define BUS_PHASE_NS 40
`define BUS_PHASE_CYC ((`BUS_PHASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GLITCH_NS 5
`define GLITCH_CYC ((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================================
// Address fields
`define ADDR_W 21
`define SECT_LSB 16
`define SECT_W 5
`define ID_SEL_BIT 0
`define ID_PROT_BIT 1
`define ID_A6_BIT 6
`define ID_A9_BIT 9

// ==========================================================
// Command encodings
`define UNLOCK1_ADDR 21'h000555
`define UNLOCK1_DATA 8'haa
`define UNLOCK2_ADDR 21'h0002aa
`define UNLOCK2_DATA 8'h55
`define IDENT_CMD 8'h90
`define PROG_CMD 8'ha0
`define RESET_CMD 8'hf0

`endif

// ### flash_prot_pkg.sv
// Types shared by the flash protection host controller
`default_nettype none
package flash_prot_pkg;
    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_PROGRAM = 2'h1,
        OP_IDENT = 2'h2,
        OP_HV_IDENT = 2'h3
    } op_t;
endpackage : flash_prot_pkg
`default_nettype wire

// ### bus_cycle.sv
// One asynchronous flash bus cycle: read or write strobe sequencer
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_params.svh"
module bus_cycle (
    input wire logic core_clk_i, // System clock
    input wire logic resetn_i, // Sync reset, active low
    input wire logic start_i, // Start one cycle
    input wire logic write_i, // 1 write, 0 read
    input wire logic [7:0] wdata_i, // Write data
    input wire logic [7:0] data_in_i, // Data lines from device
    output logic busy_o, // Cycle in progress
    output logic done_o, // One-cycle pulse at end
    output logic [7:0] rdata_o, // Captured read data
    output logic ce_n_o, // Chip select
    output logic oe_n_o, // Output enable
    output logic we_n_o, // Write strobe
    output logic [7:0] data_out_o, // Data to device
    output logic data_oe_o // High while host drives data
);
    typedef enum logic [1:0] {
        BC_IDLE = 2'h0,
        BC_STROBE = 2'h1,
        BC_RECOVER = 2'h2
    } bc_state_t;

    bc_state_t state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic wr_r, wr_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [7:0] wdata_r, wdata_nxt;

    // ==========================================================
    // Strobe sequencer
    // Strobes last several cycles, so never a sub-glitch pulse
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        wr_nxt = wr_r;
        rdata_nxt = rdata_r;
        wdata_nxt = wdata_r;
        case (state_r)
            BC_IDLE: begin
                if (start_i) begin
                    state_nxt = BC_STROBE;
                    wr_nxt = write_i;
                    wdata_nxt = wdata_i;
                    cnt_nxt = 4'(`BUS_PHASE_CYC - 1);
                end
            end
            BC_STROBE: begin
                if (cnt_r == 4'h0) begin
                    if (!wr_r) begin
                        rdata_nxt = data_in_i;
                    end
                    state_nxt = BC_RECOVER;
                    cnt_nxt = 4'(`BUS_PHASE_CYC - 1);
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            BC_RECOVER: begin
                if (cnt_r == 4'h0) begin
                    state_nxt = BC_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            default: state_nxt = BC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            state_r <= BC_IDLE;
            cnt_r <= 4'h0;
            wr_r <= 1'b0;
            rdata_r <= 8'h00;
            wdata_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            wr_r <= wr_nxt;
            rdata_r <= rdata_nxt;
            wdata_r <= wdata_nxt;
        end
    end

    // Write: ce and we low, oe high; read: ce and oe low, we high
    assign busy_o = (state_r != BC_IDLE);
    assign done_o = (state_r == BC_RECOVER) && (cnt_r == 4'h0);
    assign ce_n_o = (state_r != BC_STROBE);
    assign we_n_o = !((state_r == BC_STROBE) && wr_r);
    assign oe_n_o = !((state_r == BC_STROBE) && !wr_r);
    assign data_oe_o = wr_r && (state_r != BC_IDLE);
    assign data_out_o = wdata_r;
    assign rdata_o = rdata_r;

    AST_WRITE_OE_HIGH: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i) !we_n_o |-> (oe_n_o && !ce_n_o))
        else $error("write strobe without oe high and ce low");
    sequence strobe_hold_s;
        !ce_n_o [*4];
    endsequence
    AST_STROBE_WIDTH: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i) $fell(ce_n_o) |=> strobe_hold_s)
        else $error("strobe shorter than a bus phase");
endmodule : bus_cycle
`default_nettype wire

// ### flash_prot_host.sv
// Host controller driving a parallel flash: ident, sector status, program
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_params.svh"

// Overview of operation
// - High-voltage ident: A9 high, A6, A1 low; host forces A6 and the A9 logic level low, A1 follows the request address
// - In-system ident uses command, no high voltage
// - Protect method needs high voltage on reset
// - Protect all sectors before first unprotect
// - Alternate protect: high voltage A9 and OE
// - Program starts only after unlock cycles
// - Write needs ce and we low, oe high
// - Host starts no write cycle during lockout; reads still run
module flash_prot_host
    import flash_prot_pkg::*;
(
    input wire logic core_clk_i, // System clock 125 MHz
    input wire logic resetn_i, // Sync reset, active low
    input wire logic req_valid_i, // Request strobe
    output logic req_ready_o, // Request accepted this cycle
    input wire logic [1:0] req_op_i, // Operation, op_t
    input wire logic [`ADDR_W-1:0] req_addr_i, // Byte address
    input wire logic [7:0] req_wdata_i, // Program data
    input wire logic temp_unprot_i, // Request reset-pin high voltage
    output logic resp_valid_o, // One-cycle response pulse
    output logic [7:0] resp_rdata_o, // Read or ident data
    output logic resp_err_o, // Request refused
    input wire logic supply_lockout_level_i, // Low supply detected
    output logic [`ADDR_W-1:0] flash_addr_o, // Address pins
    output logic flash_a9_hv_o, // High voltage on A9
    output logic flash_rst_n_o, // Reset pin, active low
    output logic flash_rst_hv_o, // High voltage on reset pin
    output logic flash_ce_n_o, // Chip select, active low
    output logic flash_oe_n_o, // Output enable, active low
    output logic flash_we_n_o, // Write strobe, active low
    output logic [7:0] data_lines_o, // Data to device
    output logic data_lines_oe_o, // High while host drives data
    input wire logic [7:0] data_lines_i // Data from device
);
    typedef enum logic [2:0] {
        ST_POWERUP = 3'h0,
        ST_IDLE = 3'h1,
        ST_SEQ = 3'h2,
        ST_WAIT = 3'h3,
        ST_RESP = 3'h4
    } host_state_t;

    host_state_t state_r, state_nxt;
    op_t op_r, op_nxt;
    logic [`ADDR_W-1:0] addr_r, addr_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic [2:0] step_r, step_nxt;
    logic [2:0] nsteps_r, nsteps_nxt;
    logic err_r, err_nxt;
    logic hv_r, hv_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic bc_start, bc_write, bc_busy, bc_done;
    logic [7:0] bc_wdata, bc_rdata;
    logic [`ADDR_W-1:0] step_addr;
    logic step_is_read;

    // ==========================================================
    // Step table: unlock, unlock, command, then payload or read
    always_comb begin
        step_addr = addr_r;
        bc_wdata = wdata_r;
        step_is_read = 1'b0;
        case (step_r)
            3'h0: begin
                step_addr = `UNLOCK1_ADDR;
                bc_wdata = `UNLOCK1_DATA;
            end
            3'h1: begin
                step_addr = `UNLOCK2_ADDR;
                bc_wdata = `UNLOCK2_DATA;
            end
            3'h2: begin
                step_addr = `UNLOCK1_ADDR;
                bc_wdata = (op_r == OP_PROGRAM) ? `PROG_CMD : `IDENT_CMD;
            end
            3'h3: begin
                step_is_read = (op_r == OP_IDENT);
            end
            3'h4: begin
                step_addr = `UNLOCK1_ADDR; // Leave ident mode
                bc_wdata = `RESET_CMD;
            end
            default: begin
                step_is_read = 1'b1;
            end
        endcase
        if (op_r == OP_READ || op_r == OP_HV_IDENT) begin
            step_is_read = 1'b1;
        end
    end

    // ==========================================================
    // Request sequencer
    // Lockout refuses writes rather than queueing them
    always_comb begin
        state_nxt = state_r;
        op_nxt = op_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        step_nxt = step_r;
        nsteps_nxt = nsteps_r;
        err_nxt = err_r;
        hv_nxt = hv_r;
        rdata_nxt = rdata_r;
        bc_start = 1'b0;
        bc_write = 1'b0;
        case (state_r)
            ST_POWERUP: begin
                if (!supply_lockout_level_i) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (req_valid_i) begin
                    op_nxt = op_t'(req_op_i);
                    addr_nxt = req_addr_i;
                    wdata_nxt = req_wdata_i;
                    err_nxt = 1'b0;
                    hv_nxt = 1'b0;
                    case (op_t'(req_op_i))
                        OP_PROGRAM: begin
                            step_nxt = 3'h0;
                            nsteps_nxt = 3'h4;
                        end
                        OP_IDENT: begin
                            step_nxt = 3'h0;
                            nsteps_nxt = 3'h5;
                        end
                        OP_HV_IDENT: begin
                            step_nxt = 3'h5;
                            nsteps_nxt = 3'h6;
                            hv_nxt = !supply_lockout_level_i;
                        end
                        default: begin
                            step_nxt = 3'h5;
                            nsteps_nxt = 3'h6;
                        end
                    endcase
                    if (supply_lockout_level_i
                        && op_t'(req_op_i) != OP_READ) begin
                        err_nxt = 1'b1;
                        state_nxt = ST_RESP;
                    end else begin
                        state_nxt = ST_SEQ;
                    end
                end
            end
            ST_SEQ: begin
                if (supply_lockout_level_i && !step_is_read) begin
                    err_nxt = 1'b1;
                    hv_nxt = 1'b0;
                    state_nxt = ST_RESP;
                end else begin
                    bc_start = 1'b1;
                    bc_write = !step_is_read;
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (bc_done) begin
                    if (step_is_read) begin
                        rdata_nxt = bc_rdata;
                    end
                    if (step_r + 3'h1 == nsteps_r) begin
                        hv_nxt = 1'b0;
                        state_nxt = ST_RESP;
                    end else begin
                        step_nxt = step_r + 3'h1;
                        state_nxt = ST_SEQ;
                    end
                end
            end
            ST_RESP: begin
                state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_POWERUP;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            state_r <= ST_POWERUP;
            op_r <= OP_READ;
            addr_r <= '0;
            wdata_r <= 8'h00;
            step_r <= 3'h0;
            nsteps_r <= 3'h0;
            err_r <= 1'b0;
            hv_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            step_r <= step_nxt;
            nsteps_r <= nsteps_nxt;
            err_r <= err_nxt;
            hv_r <= hv_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    bus_cycle u_bus_cycle (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .start_i(bc_start),
        .write_i(bc_write),
        .wdata_i(bc_wdata),
        .data_in_i(data_lines_i),
        .busy_o(bc_busy),
        .done_o(bc_done),
        .rdata_o(bc_rdata),
        .ce_n_o(flash_ce_n_o),
        .oe_n_o(flash_oe_n_o),
        .we_n_o(flash_we_n_o),
        .data_out_o(data_lines_o),
        .data_oe_o(data_lines_oe_o)
    );

    // ==========================================================
    // Pin drive
    // High-voltage ident forces A6 low and parks the A9 logic level
    always_comb begin
        flash_addr_o = (state_r == ST_IDLE) ? addr_r : step_addr;
        if (hv_r) begin
            flash_addr_o[`ID_A6_BIT] = 1'b0;
            flash_addr_o[`ID_A9_BIT] = 1'b0;
        end
    end
    assign flash_a9_hv_o = hv_r;
    assign flash_rst_n_o = resetn_i;
    // Reset-pin high voltage lifts protection only while held
    assign flash_rst_hv_o = temp_unprot_i
        && !supply_lockout_level_i;
    assign req_ready_o = (state_r == ST_IDLE);
    assign resp_valid_o = (state_r == ST_RESP);
    assign resp_rdata_o = rdata_r;
    assign resp_err_o = err_r;

    AST_LOCKOUT_NO_WRITE: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        (supply_lockout_level_i && state_r == ST_SEQ) |-> !bc_write)
        else $error("write started during lockout");
    AST_POWERUP_QUIET: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i) (state_r == ST_POWERUP) |-> !bc_start)
        else $error("bus cycle during power-up");
    AST_HV_A6_LOW: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i) flash_a9_hv_o |-> !flash_addr_o[`ID_A6_BIT])
        else $error("A6 not low in high-voltage ident");
    sequence resp_pulse_s;
        resp_valid_o ##1 !resp_valid_o;
    endsequence
    AST_RESP_AFTER_DONE: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        (state_r == ST_WAIT && bc_done && step_r + 3'h1 == nsteps_r)
        |=> resp_pulse_s)
        else $error("response not one cycle after final bus cycle");
    AST_UNLOCK_FIRST: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        (bc_start && op_r == OP_PROGRAM && step_r == 3'h0)
        |-> bc_wdata == `UNLOCK1_DATA)
        else $error("program not opened by unlock");
    AST_RST_HV_GATED: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        supply_lockout_level_i |-> !flash_rst_hv_o)
        else $error("reset high voltage during lockout");
    AST_READY_IDLE: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i) (req_ready_o |-> !bc_busy))
        else $error("ready while bus busy");
    AST_IDLE_PINS: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i) req_ready_o |-> flash_we_n_o)
        else $error("write strobe low while idle");
endmodule : flash_prot_host
`default_nettype wire

// ### flash_dev_model.sv
// Behavioural model of the parallel flash behind the host controller
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_params.svh"
module flash_dev_model #(
    parameter logic [7:0] MFR_CODE = 8'h3c, // Arbitrary value
    parameter logic [7:0] DEV_CODE = 8'h5a // Arbitrary value
) (
    input wire logic [`ADDR_W-1:0] addr_i, // Address pins
    input wire logic a9_hv_i, // High voltage on A9
    input wire logic rst_n_i, // Reset pin
    input wire logic rst_hv_i, // High voltage on reset pin
    input wire logic ce_n_i, // Chip select
    input wire logic oe_n_i, // Output enable
    input wire logic we_n_i, // Write strobe
    input wire logic [7:0] data_i, // Resolved data lines
    input wire logic supply_lockout_level_i, // Low supply
    input wire logic [31:0] prot_i, // Sectors locked by programmer
    output logic [7:0] data_o // Data driven by the device
);
    // ==========================================================
    // State
    logic [7:0] mem [0:255];
    logic [1:0] step;
    logic ident, prog, pu_block;
    logic [`ADDR_W-1:0] a_lat;
    logic [7:0] d_lat, rd_val, last_val;
    realtime t_on;
    wire wr_act = !ce_n_i && !we_n_i && oe_n_i && rst_n_i;
    wire drive = !ce_n_i && !oe_n_i && we_n_i && rst_n_i;

    // Small array: sector bits plus low offset bits alias the rest
    function automatic logic [7:0] idx(input logic [`ADDR_W-1:0] a);
        return {a[20:16], a[2:0]};
    endfunction : idx

    // Power-up lands in array read with an erased array
    initial begin
        step = 2'h0;
        ident = 1'b0;
        prog = 1'b0;
        last_val = 8'h00;
        foreach (mem[i]) mem[i] = 8'hff;
        pu_block = 1'b0;
        #0.1;
        pu_block = (we_n_i === 1'b0) && (ce_n_i === 1'b0);
    end

    // Reset pin or low supply drops any command in progress
    always @(negedge rst_n_i or posedge supply_lockout_level_i) begin
        step = 2'h0;
        ident = 1'b0;
        prog = 1'b0;
    end

    // Latch address and data while the write is active
    always @(posedge wr_act) t_on = $realtime;
    always @* begin
        if (wr_act) begin
            a_lat = addr_i;
            d_lat = data_i;
        end
    end

    // Command decode at the end of each write cycle
    always @(negedge wr_act) begin
        if (supply_lockout_level_i || ($realtime - t_on) < `GLITCH_NS) begin
            step = 2'h0;
        end else if (pu_block) begin
            pu_block = 1'b0;
        end else if (prog) begin
            prog = 1'b0;
            if (!(prot_i[a_lat[20:16]] && !rst_hv_i)) begin
                mem[idx(a_lat)] = mem[idx(a_lat)] & d_lat;
            end
        end else if (d_lat == `RESET_CMD) begin
            step = 2'h0;
            ident = 1'b0;
        end else if (step == 2'h0 && a_lat == `UNLOCK1_ADDR
                     && d_lat == `UNLOCK1_DATA) begin
            step = 2'h1;
        end else if (step == 2'h1 && a_lat == `UNLOCK2_ADDR
                     && d_lat == `UNLOCK2_DATA) begin
            step = 2'h2;
        end else begin
            ident = step == 2'h2 && d_lat == `IDENT_CMD;
            prog = step == 2'h2 && d_lat == `PROG_CMD;
            step = 2'h0;
        end
    end

    // Read path: identifier codes replace array contents
    always_comb begin
        if (ident || (a9_hv_i && !addr_i[`ID_A6_BIT])) begin
            case (addr_i[1:0])
                2'h0: rd_val = MFR_CODE;
                2'h1: rd_val = DEV_CODE;
                default: rd_val = {7'h00, prot_i[addr_i[20:16]]};
            endcase
        end else begin
            rd_val = mem[idx(addr_i)];
        end
    end

    // Released lines show the inverse so stale data never passes
    always @* begin
        if (drive) last_val = rd_val;
    end
    assign data_o = drive ? rd_val : ~last_val;
endmodule : flash_dev_model
`default_nettype wire

// ### tb_top.sv
// Self-checking testbench for the flash protection host controller
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_params.svh"
module tb_top;
    import flash_prot_pkg::*;
    localparam logic [7:0] MFR = 8'h3c; // Arbitrary value
    localparam logic [7:0] DEV = 8'h5a; // Arbitrary value
    localparam int TMO_CYC = 20000;
    logic clk, rst_n, valid, ready, tunp, rvalid, rerr, lock;
    logic a9hv, f_rstn, f_rsthv, ce_n, oe_n, we_n, dq_oe;
    logic hv_seen, bad_strobe;
    logic [1:0] op;
    logic [20:0] addr, f_addr;
    logic [7:0] wdata, rdata, dq_o, dev_dq, dq_bus, wr_cnt;
    logic [31:0] prot;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;

    // ==========================================================
    // Design, device model and the shared data lines
    assign dq_bus = dq_oe ? dq_o : dev_dq;
    flash_prot_host u_dut (.core_clk_i(clk), .resetn_i(rst_n),
        .req_valid_i(valid), .req_ready_o(ready), .req_op_i(op),
        .req_addr_i(addr), .req_wdata_i(wdata), .temp_unprot_i(tunp),
        .resp_valid_o(rvalid), .resp_rdata_o(rdata), .resp_err_o(rerr),
        .supply_lockout_level_i(lock), .flash_addr_o(f_addr),
        .flash_a9_hv_o(a9hv), .flash_rst_n_o(f_rstn),
        .flash_rst_hv_o(f_rsthv), .flash_ce_n_o(ce_n),
        .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .data_lines_o(dq_o),
        .data_lines_oe_o(dq_oe), .data_lines_i(dq_bus));
    flash_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_flash (
        .addr_i(f_addr), .a9_hv_i(a9hv), .rst_n_i(f_rstn),
        .rst_hv_i(f_rsthv), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .data_i(dq_bus), .supply_lockout_level_i(lock), .prot_i(prot),
        .data_o(dev_dq));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Monitors of the pins plus a hang guard
    initial wr_cnt = 8'h00;
    initial bad_strobe = 1'b0;
    always @(negedge we_n) wr_cnt <= wr_cnt + 8'h01;
    always @(posedge clk) begin
        if (a9hv === 1'b1) hv_seen <= 1'b1;
        if (we_n === 1'b0 && (oe_n !== 1'b1 || ce_n !== 1'b0))
            bad_strobe <= 1'b1;
        cyc++;
        if (cyc == TMO_CYC) begin
            fail_count++;
            finish_test();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask : check

    // One request; returns at the falling edge that shows the response
    task automatic do_req(input logic [1:0] o, input logic [20:0] a,
                          input logic [7:0] d);
        int n;
        op = o;
        addr = a;
        wdata = d;
        valid = 1'b1;
        n = 0;
        while (ready !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        // A request that is never taken must not pass silently
        if (n >= 200) fail_count++;
        @(negedge clk);
        valid = 1'b0;
        n = 0;
        while (rvalid !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (n >= 300) fail_count++;
    endtask : do_req

    task automatic finish_test();
        $display("counts: %0d compares, %0d mismatches", n_tests,
                 fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    // ==========================================================
    // Scenarios
    task automatic t_ident();
        check({7'h00, f_rstn}, 8'h01);
        for (int m = 2; m < 4; m++) begin
            hv_seen = 1'b0;
            do_req(m[1:0], 21'h000000, 8'h00);
            check(rdata, MFR);
            do_req(m[1:0], 21'h000001, 8'h00);
            check(rdata, DEV);
            do_req(m[1:0], 21'h030002, 8'h00);
            check(rdata, 8'h00);
            check({7'h00, hv_seen}, {7'h00, m[0]});
        end
        $display("t_ident finished");
    endtask : t_ident

    task automatic t_program();
        wr_cnt = 8'h00;
        do_req(OP_PROGRAM, 21'h020005, 8'h3c);
        check(wr_cnt, 8'h04);
        check({7'h00, rerr}, 8'h00);
        do_req(OP_READ, 21'h020005, 8'h00);
        check(rdata, 8'h3c);
        do_req(OP_READ, 21'h020006, 8'h00);
        check(rdata, 8'hff);
        $display("t_program finished");
    endtask : t_program

    task automatic t_protect();
        prot = 32'h00000020; // Sector 5 locked by a programmer
        do_req(OP_HV_IDENT, 21'h050002, 8'h00);
        check(rdata, 8'h01);
        do_req(OP_PROGRAM, 21'h050001, 8'h00);
        do_req(OP_READ, 21'h050001, 8'h00);
        check(rdata, 8'hff);
        tunp = 1'b1;
        @(negedge clk);
        check({7'h00, f_rsthv}, 8'h01);
        do_req(OP_PROGRAM, 21'h050001, 8'h0f);
        do_req(OP_READ, 21'h050001, 8'h00);
        check(rdata, 8'h0f);
        tunp = 1'b0;
        @(negedge clk);
        do_req(OP_PROGRAM, 21'h050002, 8'h00);
        do_req(OP_READ, 21'h050002, 8'h00);
        check(rdata, 8'hff);
        $display("t_protect finished");
    endtask : t_protect

    task automatic t_lockout();
        lock = 1'b1;
        tunp = 1'b1;
        @(negedge clk);
        check({7'h00, f_rsthv}, 8'h00);
        wr_cnt = 8'h00;
        do_req(OP_PROGRAM, 21'h020006, 8'h00);
        check({7'h00, rerr}, 8'h01);
        do_req(OP_IDENT, 21'h000000, 8'h00);
        check({7'h00, rerr}, 8'h01);
        do_req(OP_HV_IDENT, 21'h000000, 8'h00);
        check({7'h00, rerr}, 8'h01);
        check({7'h00, a9hv}, 8'h00);
        check(wr_cnt, 8'h00);
        lock = 1'b0;
        tunp = 1'b0;
        repeat (2) @(negedge clk);
        do_req(OP_READ, 21'h020006, 8'h00);
        check(rdata, 8'hff);
        check({7'h00, rerr}, 8'h00);
        $display("t_lockout finished");
    endtask : t_lockout

    // Main sequence
    initial begin
        valid = 1'b0;
        op = 2'h0;
        addr = 21'h000000;
        wdata = 8'h00;
        tunp = 1'b0;
        lock = 1'b0;
        hv_seen = 1'b0;
        prot = 32'h00000000;
        rst_n = 1'b0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        t_ident();
        t_program();
        t_protect();
        t_lockout();
        check({7'h00, bad_strobe}, 8'h00);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
